// ---- arf_pkg.sv ----
/*
 Package for the converter result formatting block: register offsets,
 field positions, reset values and the conversion timing count.
 Assumes an APB slave with 32-bit data, one aligned word per register.
*/
`default_nettype none
package arf_pkg;
   // ====================================================================
   // Register byte offsets (APB word aligned)
   localparam logic [7:0] ARF_OFS_RESULT_HIGH = 8'h00;
   localparam logic [7:0] ARF_OFS_RESULT_LOW = 8'h04;
   localparam logic [7:0] ARF_OFS_CONTROL = 8'h08;
   localparam logic [7:0] ARF_OFS_ANALOG_SEL = 8'h0C;
   localparam logic [7:0] ARF_OFS_IRQ = 8'h10;
   // ====================================================================
   // Control register fields
   localparam int ARF_CTL_JUSTIFY = 7;
   localparam int ARF_CTL_REFSEL = 6;
   localparam int ARF_CTL_CHS_HI = 3;
   localparam int ARF_CTL_CHS_LO = 2;
   localparam int ARF_CTL_GO = 1;
   localparam int ARF_CTL_ON = 0;
   // Implemented control bits (5-4 read as zero)
   localparam logic [7:0] ARF_CTL_MASK = 8'hCF;
   localparam logic [7:0] ARF_CTL_RESET = 8'h00;
   // Analog select / clock select: bit 7 unimplemented
   localparam logic [7:0] ARF_ANS_MASK = 8'h7F;
   localparam logic [7:0] ARF_ANS_RESET = 8'h0F;
   // Interrupt register: bit 0 flag (write one clears), bit 1 enable
   localparam int ARF_IRQ_FLAG = 0;
   localparam int ARF_IRQ_EN = 1;
   // ====================================================================
   // Conversion timing
   localparam int ARF_CLK_HZ = 20_000_000;
   localparam int ARF_CONV_NS = 2_000;
   localparam int ARF_CONV_CYC = (ARF_CONV_NS * (ARF_CLK_HZ / 1_000_000) + 999) / 1000;
   // State machine codes
   typedef enum logic [1:0] {
      ARF_IDLE = 2'b01,
      ARF_CONV = 2'b10
   } arf_state_t;
endpackage : arf_pkg
`default_nettype wire

// ---- arf_top.sv ----
/*
 Result formatting and control of a 10-bit converter: control and
 analog-select registers, channel mux, conversion sequencer and the
 justified result registers, reached over APB.
 Assumes a sample source presenting four 10-bit channel codes on
 ain_code, synchronous to ref_clk. por_rst marks power-on/brown-out.
 Assumes software waits out acquisition after a channel change; the
 block does not time it. Each register sits in the low byte of an
 aligned APB word; srst leaves the result bytes alone.
*/
// Local design decisions: the address map and register access over APB.
`default_nettype none
module arf_top
   import arf_pkg::*;
#(
   parameter int CONV_CYCLES = ARF_CONV_CYC
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic por_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [39:0] ain_code,
   output logic [1:0] channel_select,
   output logic converter_on,
   output logic reference_source_select,
   output logic [3:0] analog_pin_select,
   output logic [2:0] conversion_clock_select,
   output logic conversion_irq
);
   // ====================================================================
   // Parameter check
   // The cycle counter is 16 bits; a zero count would wrap and take 65536 cycles
   if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_cycles
      $error("CONV_CYCLES out of range");
   end

   // ====================================================================
   // Register state
   // Each register pairs its flip-flop (_q) with its next value (_d)
   logic [7:0] ctl_q, ctl_d;           // Converter control
   logic [7:0] ans_q, ans_d;           // Analog and clock select
   logic [7:0] rhi_q, rhi_d;           // Result high byte
   logic [7:0] rlo_q, rlo_d;           // Result low byte
   logic flag_q, flag_d;               // Completion flag
   logic ien_q, ien_d;                 // Completion interrupt enable
   logic irq_q, irq_d;                 // Registered interrupt line
   logic [31:0] rdata_q, rdata_d;      // Read data
   logic ready_q, ready_d;             // Access phase answer
   logic err_q, err_d;                 // Slave error
   arf_state_t st_q, st_d;             // Sequencer state
   logic [15:0] cnt_q, cnt_d;          // Conversion cycle counter

   // ====================================================================
   // Helper functions
   // Format a 10-bit code into high/low bytes by the justify bit
   function automatic logic [15:0] arf_format(input logic right, input logic [9:0] r);
      if (right) begin
         arf_format = {6'h00, r[9:8], r[7:0]};
      end else begin
         arf_format = {r[9:2], r[1:0], 6'h00};
      end
   endfunction : arf_format

   // True for the five mapped word offsets; the rest answer with an error
   function automatic logic arf_mapped(input logic [7:0] a);
      arf_mapped = (a == ARF_OFS_RESULT_HIGH) || (a == ARF_OFS_RESULT_LOW) ||
         (a == ARF_OFS_CONTROL) || (a == ARF_OFS_ANALOG_SEL) || (a == ARF_OFS_IRQ);
   endfunction : arf_mapped

   // ====================================================================
   // Bus decode helpers
   // Only the first access cycle acts; the answer cycle must not act again
   logic wr_acc;                       // Write in its first access cycle
   logic rd_acc;                       // Read in its first access cycle
   logic conv_done;                    // Last counted cycle of a conversion
   logic [9:0] sel_code;               // Code of the selected input
   logic [15:0] fmt;                   // Justified result, high then low byte
   assign wr_acc = psel && penable && pwrite && !ready_q;
   assign rd_acc = psel && penable && !pwrite && !ready_q;
   // Input mux by channel field
   // Channel n sits at bits 10n+9 down to 10n of ain_code
   assign sel_code = ain_code[ctl_q[ARF_CTL_CHS_HI:ARF_CTL_CHS_LO] * 10 +: 10];
   // Layout follows the justify bit as it stands at completion
   assign fmt = arf_format(ctl_q[ARF_CTL_JUSTIFY], sel_code);
   // Counter end point: CONV_CYCLES cycles spent in the converting state
   assign conv_done = (st_q == ARF_CONV) && (cnt_q == 16'(CONV_CYCLES - 1));

   // ====================================================================
   // Bus answer: one wait state, error pulse on unmapped offsets
   // Read data is registered, so it stands with pready and after it
   always_comb begin
      ready_d = 1'b0;
      err_d = 1'b0;
      rdata_d = rdata_q;               // Holds until the next read
      // Answer the cycle after the access phase begins
      if (psel && penable && !ready_q) begin
         ready_d = 1'b1;
      end
      // Unmapped offset: refused, answered with an error
      if ((wr_acc || rd_acc) && !arf_mapped(paddr)) begin
         err_d = 1'b1;
      end
      // Read multiplexer; registers sit in the low byte
      if (rd_acc) begin
         if (paddr == ARF_OFS_RESULT_HIGH) begin
            rdata_d = {24'h00_0000, rhi_q};
         end else if (paddr == ARF_OFS_RESULT_LOW) begin
            rdata_d = {24'h00_0000, rlo_q};
         end else if (paddr == ARF_OFS_CONTROL) begin
            rdata_d = {24'h00_0000, ctl_q};
         end else if (paddr == ARF_OFS_ANALOG_SEL) begin
            rdata_d = {24'h00_0000, ans_q};
         end else if (paddr == ARF_OFS_IRQ) begin
            rdata_d = {24'h00_0000, 6'h00, ien_q, flag_q};
         end else begin
            rdata_d = 32'h0000_0000;  // Unmapped reads as zero
         end
      end
   end

   // Bus answer registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ready_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ready_q <= ready_d;
         err_q <= err_d;
         rdata_q <= rdata_d;
      end
   end

   // ====================================================================
   // Control, analog select and interrupt enable
   // Reserved control bits 5-4 and select bit 7 are masked off on write
   always_comb begin
      ctl_d = ctl_q;
      ans_d = ans_q;
      ien_d = ien_q;
      // Software writes, one register per access
      if (wr_acc && paddr == ARF_OFS_CONTROL) begin
         // Go is hardware-owned while converting; writing 0 cannot abort
         ctl_d = (pwdata[7:0] & ARF_CTL_MASK) | {6'h00, ctl_q[ARF_CTL_GO], 1'b0};
         if (st_q == ARF_IDLE) begin
            ctl_d[ARF_CTL_GO] = pwdata[ARF_CTL_GO];
         end
      end else if (wr_acc && paddr == ARF_OFS_ANALOG_SEL) begin
         ans_d = pwdata[7:0] & ARF_ANS_MASK;
      end else if (wr_acc && paddr == ARF_OFS_IRQ) begin
         ien_d = pwdata[ARF_IRQ_EN];
      end
      // Hardware clears go; this wins over a same-cycle write
      if (conv_done) begin
         ctl_d[ARF_CTL_GO] = 1'b0;
      end else if (st_q == ARF_IDLE && ctl_q[ARF_CTL_GO] && !ctl_q[ARF_CTL_ON]) begin
         ctl_d[ARF_CTL_GO] = 1'b0;  // Converter off: nothing to do
      end
   end

   // Control registers; srst restores their reset values
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctl_q <= ARF_CTL_RESET;
         ans_q <= ARF_ANS_RESET;
         ien_q <= 1'b0;
      end else begin
         ctl_q <= ctl_d;
         ans_q <= ans_d;
         ien_q <= ien_d;
      end
   end

   // ====================================================================
   // Conversion sequencer
   // Acquisition time is software's duty: go with the converter on starts
   // the count at once, so a go set too early converts an unsettled input
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      // Two states only: idle and converting
      case (st_q)
         ARF_IDLE: begin
            // Start on go with the converter enabled
            if (ctl_q[ARF_CTL_GO] && ctl_q[ARF_CTL_ON]) begin
               st_d = ARF_CONV;
               cnt_d = 16'h0000;
            end
         end
         ARF_CONV: begin
            // Count up to the end point, then fall back to idle
            if (conv_done) begin
               st_d = ARF_IDLE;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         default: begin
            st_d = ARF_IDLE;        // Illegal code recovers to idle
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q <= ARF_IDLE;
         cnt_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // ====================================================================
   // Completion flag and interrupt line
   // The line is registered from the next flag and enable, so it changes on the same edge as they do
   always_comb begin
      flag_d = flag_q;
      // Software clear: write one to the flag bit
      if (wr_acc && paddr == ARF_OFS_IRQ && pwdata[ARF_IRQ_FLAG]) begin
         flag_d = 1'b0;
      end
      // Set wins over a clear in the same cycle, so no completion is lost
      if (conv_done) begin
         flag_d = 1'b1;
      end
      irq_d = flag_d && ien_d;
   end

   // Flag and interrupt registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flag_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         irq_q <= irq_d;
      end
   end

   // ====================================================================
   // Result bytes
   // Software may overwrite them; a completing conversion wins the cycle
   always_comb begin
      rhi_d = rhi_q;
      rlo_d = rlo_q;
      if (wr_acc && paddr == ARF_OFS_RESULT_HIGH) begin
         rhi_d = pwdata[7:0];
      end else if (wr_acc && paddr == ARF_OFS_RESULT_LOW) begin
         rlo_d = pwdata[7:0];
      end
      // Conversion result, justified by the control bit
      if (conv_done) begin
         rhi_d = fmt[15:8];
         rlo_d = fmt[7:0];
      end
   end

   // Result bytes: untouched by srst; cleared only on power-on for a defined sim start
   always_ff @(posedge ref_clk) begin
      if (por_rst) begin
         rhi_q <= 8'h00;
         rlo_q <= 8'h00;
      end else begin
         rhi_q <= rhi_d;
         rlo_q <= rlo_d;
      end
   end

   // ====================================================================
   // Outputs straight from flip-flops
   // pready and pslverr are one-cycle pulses; prdata holds the last read
   // Pin fields are slices of the registers, so they need no extra stage
   // and change on the edge that lands the write
   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = err_q;
   assign channel_select = ctl_q[ARF_CTL_CHS_HI:ARF_CTL_CHS_LO];
   assign converter_on = ctl_q[ARF_CTL_ON];
   assign reference_source_select = ctl_q[ARF_CTL_REFSEL];
   assign analog_pin_select = ans_q[3:0];
   assign conversion_clock_select = ans_q[6:4];
   assign conversion_irq = irq_q;
endmodule : arf_top
`default_nettype wire

// ---- arf_checker.sv ----
/* Checker for the result formatting block: APB handshake and pin relations.
 Assumes binding to arf_top ports; one domain, ref_clk with srst. */
`default_nettype none
module arf_checker (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] channel_select,
   input wire logic converter_on,
   input wire logic conversion_irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // ===================================
   // Handshake: one wait state, single pulse
   chk_ready_wait: assert property ($rose(penable) && psel |=> pready)
      else $error("pready not one cycle after access");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_ready_req: assert property (pready |-> psel && penable)
      else $error("pready without request");
   chk_err_map: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h10))
      else $error("pslverr wrong for address");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // ===================================
   // Register content seen at the pins
   chk_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   chk_ctl_pins: assert property (pready && pwrite && paddr == 8'h08 |=>
      channel_select == $past(pwdata[3:2]) && converter_on == $past(pwdata[0]))
      else $error("control pins differ from write");
   chk_rst_vals: assert property ($fell(srst) |-> !converter_on && !conversion_irq)
      else $error("reset values wrong");
   // Main scenarios reached
   cov_rd: cover property (pready && !pwrite);
   cov_err: cover property (pslverr);
   cov_irq: cover property ($rose(conversion_irq));
endmodule : arf_checker
bind arf_top arf_checker i_chk (.ref_clk(ref_clk), .srst(srst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .channel_select(channel_select),
   .converter_on(converter_on), .conversion_irq(conversion_irq));
`default_nettype wire

// ---- arf_ain_model.sv ----
/* Sample source model: four 10-bit channel codes made from a seed.
 Assumes the block samples ain_code at conversion end; codes held steady. */
`default_nettype none
module arf_ain_model (
   input wire logic [9:0] seed,
   output logic [39:0] ain_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // Distinct code per input, so a wrong channel pick shows
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         ain_code[10*n +: 10] = seed + 10'(n) * 10'h101;
      end
   end
endmodule : arf_ain_model
`default_nettype wire

// ---- arf_top_tb_top.sv ----
/* Testbench for the result formatting block: APB tasks, conversions.
 Assumes arf_top with a short conversion count and the source model. */
`default_nettype none
module arf_top_tb_top import arf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, srst = 1, por_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, hi, ctl;
   logic pready, pslverr, converter_on, reference_source_select, conversion_irq, er;
   logic [1:0] channel_select;
   logic [3:0] analog_pin_select;
   logic [2:0] conversion_clock_select;
   logic [39:0] ain_code;
   logic [9:0] seed = 10'h2C5, code;
   int error_cnt = 0, compares = 0;
   // ===================================
   // Clock and instances
   always #25 ref_clk = ~ref_clk;
   arf_top #(.CONV_CYCLES(3)) i_dut (.ref_clk(ref_clk), .srst(srst), .por_rst(por_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ain_code(ain_code),
      .channel_select(channel_select), .converter_on(converter_on),
      .reference_source_select(reference_source_select),
      .analog_pin_select(analog_pin_select), .conversion_clock_select(conversion_clock_select),
      .conversion_irq(conversion_irq));
   arf_ain_model i_src (.seed(seed), .ain_code(ain_code));
   // ===================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   // Bounded wait on pready; extra edge so no signal is driven twice
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         $display("ERROR %0t no pready", $time);
         report_and_stop;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   // ===================================
   // Main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      por_rst <= 1'b0;
      @(posedge ref_clk);
      apb(0, ARF_OFS_CONTROL, 0);
      chk(rd, 32'h0000_0000);
      apb(0, ARF_OFS_ANALOG_SEL, 0);
      chk(rd, 32'h0000_000F);
      apb(1, 8'h14, 32'h0000_00FF);
      chk(32'(er), 32'h0000_0001);
      // Select register: bit 7 reads zero, its fields reach the pins
      apb(1, ARF_OFS_ANALOG_SEL, 32'h0000_00FF);
      apb(0, ARF_OFS_ANALOG_SEL, 0);
      chk(rd, 32'h0000_007F);
      chk(32'(analog_pin_select), 32'h0000_000F);
      chk(32'(conversion_clock_select), 32'h0000_0007);
      apb(1, ARF_OFS_IRQ, 32'h0000_0002);
      // Every channel in both layouts, reference bit toggled
      for (int j = 0; j < 8; j++) begin
         code = seed + 10'(j % 4) * 10'h101;
         ctl = 32'(j / 4) << 7 | 32'(j % 2) << 6 | 32'(j % 4) << 2 | 32'h0000_0001;
         apb(1, ARF_OFS_CONTROL, ctl | 32'h0000_0030);
         chk(32'(channel_select), 32'(j % 4));
         chk(32'(reference_source_select), 32'(j % 2));
         apb(0, ARF_OFS_CONTROL, 0);
         chk(rd, ctl);
         repeat (5) @(posedge ref_clk);
         apb(1, ARF_OFS_CONTROL, ctl | 32'h0000_0002);
         // Poll go until hardware clears it; at least one read first
         apb(0, ARF_OFS_CONTROL, 0);
         for (int i = 0; i < 20 && rd[1] !== 1'b0; i++) apb(0, ARF_OFS_CONTROL, 0);
         chk(32'(rd[1]), 32'h0000_0000);
         chk(32'(conversion_irq), 32'h0000_0001);
         apb(1, ARF_OFS_IRQ, 32'h0000_0003);
         chk(32'(conversion_irq), 32'h0000_0000);
         apb(0, ARF_OFS_RESULT_HIGH, 0);
         hi = rd;
         apb(0, ARF_OFS_RESULT_LOW, 0);
         if (j >= 4) begin
            chk(hi & 32'h0000_0003, 32'(code[9:8]));
            chk(rd, 32'(code[7:0]));
         end else begin
            chk(hi, 32'(code[9:2]));
            chk(rd & 32'h0000_00C0, 32'(code[1:0]) << 6);
         end
      end
      // Mid-run reset keeps the result; go with converter off is dropped
      srst <= 1'b1;
      @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      apb(0, ARF_OFS_RESULT_LOW, 0);
      chk(rd, 32'(code[7:0]));
      apb(0, ARF_OFS_RESULT_HIGH, 0);
      chk(rd & 32'h0000_0003, 32'(code[9:8]));
      apb(0, ARF_OFS_ANALOG_SEL, 0);
      chk(rd, 32'h0000_000F);
      apb(1, ARF_OFS_CONTROL, 32'h0000_0002);
      apb(0, ARF_OFS_CONTROL, 0);
      chk(rd, 32'h0000_0000);
      // No conversion ran, so the flag stays clear
      apb(0, ARF_OFS_IRQ, 0);
      chk(rd, 32'h0000_0000);
      report_and_stop;
   end
endmodule : arf_top_tb_top
`default_nettype wire
